// ==== hw/qltsi_tx_system_interface.sv ====
// transmit system-side input logic, mode selection and register file
//
// Notes on behaviour
// - dual-rail samples plus and minus inputs together on selected clock edge.
// - dual-rail plus sampled high gives positive pulse, low gives none.
// - dual-rail minus sampled high gives negative pulse, low gives none.
// - single-rail samples the whole stream and encodes bipolar pulses.
// - host control with single-rail ignores the minus input entirely.
// - pin control single-rail: code select low enables encoder, high disables.
// - encoder on gives HDB3 for E1, B8ZS for T1; off gives AMI.
// - each channel's line clock times its whole transmit path.
// - pin control: all-ones input high sends unframed ones, low normal.
// - host control: all-ones pins are bus controls, not pattern commands.
// - transmit enable turns on only transmitter; low tri-states line outputs.
// - pin control keeps receivers powered; host control switches each one.
// - host control enable bits switch transmitters; handover bit returns pins.
// - control select low picks host control, high or floating pins.
// - host control takes registers from port; pin control disables port.
// - write strobe low enables data input; register latches on rising edge.
// - strobe-style bus reads when select is high as strobe falls.
// - pin control edge select: high rising, low falling sampling edge.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module qltsi_tx_system_interface
  import qltsi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [NUM_CH-1:0] txLineClock,
  input wire logic [NUM_CH-1:0] txPlusRailIn,
  input wire logic [NUM_CH-1:0] txMinusRailIn,
  input wire logic [NUM_CH-1:0] txAllOnesCmd,
  input wire logic [NUM_CH-1:0] txSectionEnable,
  input wire logic controlSourceSelect,
  input wire logic txClockEdgeSelect,
  input wire logic singleRailSelect,
  input wire logic e1StandardSelect,
  input wire logic busStyleSelect,
  input wire logic [6:0] busAddr,
  input wire logic [7:0] busDataIn,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  output logic [NUM_CH-1:0] lineOutPlus,
  output logic [NUM_CH-1:0] lineOutMinus,
  output logic [NUM_CH-1:0] lineOutOe,
  output logic [NUM_CH-1:0] rxPowerOn,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  qltsi_chan_pins_t chanMeta_ff [NUM_CH];
  qltsi_chan_pins_t chanSync_ff [NUM_CH];
  qltsi_glob_pins_t globMeta_ff;
  qltsi_glob_pins_t globSync_ff;
  logic [7:0] chanCtrl_ff [NUM_CH];
  logic [7:0] nxt_chanCtrl [NUM_CH];
  logic [7:0] global_ff;
  logic [7:0] nxt_global;
  logic [7:0] statusWord;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic [7:0] busDataOut_ff;
  logic [7:0] nxt_busDataOut;
  logic busDataOe_ff;
  logic nxt_busDataOe;
  logic strobePrev_ff;
  logic nxt_strobePrev;
  logic csPrev_ff;
  logic nxt_csPrev;
  logic hostMode;
  logic singleRail;
  logic e1Mode;
  logic risingSel;
  logic pinHandover;
  logic [6:0] apbIdx;
  logic apbMapped;
  logic apbWrite;
  logic portWrite;
  logic portRead;
  logic wrEn;
  logic [6:0] wrIdx;
  logic [7:0] wrData;
  logic [NUM_CH-1:0] sampleEdge;
  logic [NUM_CH-1:0] codecEn;
  logic [NUM_CH-1:0] allOnes;
  logic [NUM_CH-1:0] txEn;
  logic [15:0] sym_ff [NUM_CH];
  logic [15:0] nxt_sym [NUM_CH];
  logic [NUM_CH-1:0] lastPol_ff;
  logic [NUM_CH-1:0] nxt_lastPol;
  logic [NUM_CH-1:0] parity_ff;
  logic [NUM_CH-1:0] nxt_parity;
  logic [NUM_CH-1:0] clkPrev_ff;
  logic [NUM_CH-1:0] linePlus_ff;
  logic [NUM_CH-1:0] nxt_linePlus;
  logic [NUM_CH-1:0] lineMinus_ff;
  logic [NUM_CH-1:0] nxt_lineMinus;

  // register read decode, shared by the bus slave and the strobe port
  function automatic logic [7:0] regRead(input logic [6:0] idx);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (idx == 7'(IDX_CH_CTRL0 + i)) r = chanCtrl_ff[i];
    end
    if (idx == IDX_GLOBAL) r = global_ff;
    if (idx == IDX_STATUS) r = statusWord;
    return r;
  endfunction : regRead

  function automatic logic regMapped(input logic [6:0] idx);
    return (idx < 7'(IDX_CH_CTRL0 + NUM_CH)) || (idx == IDX_GLOBAL) || (idx == IDX_STATUS);
  endfunction : regMapped

  // two-stage synchronisers; the host bus fields settle long before the strobe edge
  always_ff @(posedge clk) begin
    if (srst) begin
      globMeta_ff <= '0;
      globSync_ff <= '0;
    end else begin
      globMeta_ff <= '{controlSourceSelect, txClockEdgeSelect, singleRailSelect,
                       e1StandardSelect, busStyleSelect, busAddr, busDataIn};
      globSync_ff <= globMeta_ff;
    end
  end

  // device-wide mode selection
  assign hostMode = !globSync_ff.ctlSrc;
  assign singleRail = hostMode ? global_ff[GC_SINGLE_RAIL] : globSync_ff.singleRail;
  assign e1Mode = hostMode ? global_ff[GC_E1] : globSync_ff.e1;
  assign risingSel = hostMode ? global_ff[GC_RISING] : globSync_ff.edgeSel;
  assign pinHandover = global_ff[GC_PIN_HANDOVER];

  // status word shows effective modes and transmitter state
  always_comb begin
    statusWord = 8'h00;
    statusWord[ST_HOST] = hostMode;
    statusWord[ST_SINGLE_RAIL] = singleRail;
    statusWord[ST_E1] = e1Mode;
    statusWord[ST_TX_EN_LSB +: NUM_CH] = txEn;
  end

  // apb slave: zero wait, read data captured in the setup cycle
  assign apbIdx = paddr[APB_IDX_MSB:APB_IDX_LSB];
  assign apbMapped = regMapped(apbIdx) && (paddr[APB_ADDR_W-1:APB_IDX_MSB+1] == '0);
  assign apbWrite = psel && penable && pwrite && apbMapped;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !apbMapped;
  assign prdata = prdata_ff;

  // strobe port on the shared all-ones pins, live only under host control
  always_comb begin
    logic wrStrobe;
    logic dsStrobe;
    logic csN;
    wrStrobe = chanSync_ff[0].allOnes;
    dsStrobe = chanSync_ff[1].allOnes;
    csN = chanSync_ff[3].allOnes;
    nxt_strobePrev = globSync_ff.busStyle ? dsStrobe : wrStrobe;
    nxt_csPrev = csN;
    portWrite = 1'b0;
    if (hostMode && !globSync_ff.busStyle) begin
      portWrite = wrStrobe && !strobePrev_ff && !csPrev_ff;
    end else if (hostMode) begin
      portWrite = !dsStrobe && strobePrev_ff && !csN && !wrStrobe;
    end
    portRead = hostMode && !csN && !dsStrobe && (!globSync_ff.busStyle || wrStrobe);
    nxt_busDataOut = regRead(globSync_ff.addr);
    nxt_busDataOe = portRead;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strobePrev_ff <= 1'b1;
      csPrev_ff <= 1'b1;
      busDataOut_ff <= 8'h00;
      busDataOe_ff <= 1'b0;
    end else begin
      strobePrev_ff <= nxt_strobePrev;
      csPrev_ff <= nxt_csPrev;
      busDataOut_ff <= nxt_busDataOut;
      busDataOe_ff <= nxt_busDataOe;
    end
  end
  assign busDataOut = busDataOut_ff;
  assign busDataOe = busDataOe_ff;

  // register file: bus slave wins over the strobe port in the same cycle
  assign wrEn = apbWrite || portWrite;
  assign wrIdx = apbWrite ? apbIdx : globSync_ff.addr;
  assign wrData = apbWrite ? pwdata[7:0] : globSync_ff.data;
  always_comb begin
    nxt_chanCtrl = chanCtrl_ff;
    nxt_global = global_ff;
    nxt_prdata = prdata_ff;
    if (psel && !penable) nxt_prdata = {24'h000000, regRead(apbIdx)};
    for (int i = 0; i < NUM_CH; i++) begin
      if (wrEn && wrIdx == 7'(IDX_CH_CTRL0 + i)) nxt_chanCtrl[i] = wrData & CC_WMASK;
    end
    if (wrEn && wrIdx == IDX_GLOBAL) nxt_global = wrData & GC_WMASK;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CH; i++) chanCtrl_ff[i] <= CC_RST;
      global_ff <= GC_RST;
      prdata_ff <= 32'h00000000;
    end else begin
      chanCtrl_ff <= nxt_chanCtrl;
      global_ff <= nxt_global;
      prdata_ff <= nxt_prdata;
    end
  end

  // per-channel transmit path, advanced only on the line clock's chosen edge
  for (genvar g = 0; g < NUM_CH; g++) begin : gChan
    logic clkNow;
    assign clkNow = chanSync_ff[g].clk;
    assign sampleEdge[g] = risingSel ? (clkNow && !clkPrev_ff[g]) : (!clkNow && clkPrev_ff[g]);
    assign codecEn[g] = singleRail && (hostMode ? chanCtrl_ff[g][CC_CODEC_EN]
                                                : !chanSync_ff[g].minus);
    assign allOnes[g] = hostMode ? chanCtrl_ff[g][CC_ALL_ONES] : chanSync_ff[g].allOnes;
    assign txEn[g] = (!hostMode || pinHandover) ? chanSync_ff[g].txOn
                                                : chanCtrl_ff[g][CC_TX_EN];
    assign rxPowerOn[g] = hostMode ? chanCtrl_ff[g][CC_RX_PWR] : 1'b1;
    assign lineOutOe[g] = txEn[g];
    assign lineOutPlus[g] = linePlus_ff[g];
    assign lineOutMinus[g] = lineMinus_ff[g];

    always_comb begin
      logic [15:0] sh;
      logic [15:0] mask;
      logic [15:0] pat;
      logic [2:0] tap;
      logic [1:0] s;
      logic p;
      logic m;
      sh = sym_ff[g];
      mask = 16'h0000;
      pat = 16'h0000;
      tap = TAP_AMI;
      s = SYM_ZERO;
      p = linePlus_ff[g];
      m = lineMinus_ff[g];
      nxt_sym[g] = sym_ff[g];
      nxt_lastPol[g] = lastPol_ff[g];
      nxt_parity[g] = parity_ff[g];
      // odd pulse count since last violation needs no balancing mark
      if (e1Mode) begin
        tap = TAP_HDB3;
        mask = MASK_HDB3;
        pat = parity_ff[g] ? PAT_HDB3_ODD : PAT_HDB3_EVEN;
      end else begin
        tap = TAP_B8ZS;
        mask = MASK_B8ZS;
        pat = PAT_B8ZS;
      end
      if (!codecEn[g]) tap = TAP_AMI;
      if (sampleEdge[g]) begin
        sh = {sym_ff[g][13:0], chanSync_ff[g].plus ? SYM_MARK : SYM_ZERO};
        if (codecEn[g] && ((sh & mask) == 16'h0000)) sh = (sh & ~mask) | pat;
        s = sh[{tap, 1'b0} +: 2];
        if (allOnes[g]) s = SYM_MARK;
        nxt_sym[g] = sh;
        unique case (s)
          SYM_ZERO: begin
            p = 1'b0;
            m = 1'b0;
          end
          SYM_MARK, SYM_BIP: begin
            p = !lastPol_ff[g];
            m = lastPol_ff[g];
            nxt_lastPol[g] = !lastPol_ff[g];
            nxt_parity[g] = !parity_ff[g];
          end
          SYM_VIOL: begin
            p = lastPol_ff[g];
            m = !lastPol_ff[g];
            nxt_parity[g] = 1'b0;
          end
        endcase
        // rails drive the line directly only in dual-rail mode
        if (!singleRail && !allOnes[g]) begin
          p = chanSync_ff[g].plus;
          m = chanSync_ff[g].minus;
        end
      end
      nxt_linePlus[g] = p;
      nxt_lineMinus[g] = m;
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        chanMeta_ff[g] <= '0;
        chanSync_ff[g] <= '0;
        clkPrev_ff[g] <= 1'b0;
        sym_ff[g] <= 16'h0000;
        lastPol_ff[g] <= 1'b0;
        parity_ff[g] <= 1'b0;
        linePlus_ff[g] <= 1'b0;
        lineMinus_ff[g] <= 1'b0;
      end else begin
        chanMeta_ff[g] <= '{txLineClock[g], txPlusRailIn[g], txMinusRailIn[g],
                            txAllOnesCmd[g], txSectionEnable[g]};
        chanSync_ff[g] <= chanMeta_ff[g];
        clkPrev_ff[g] <= clkNow;
        sym_ff[g] <= nxt_sym[g];
        lastPol_ff[g] <= nxt_lastPol[g];
        parity_ff[g] <= nxt_parity[g];
        linePlus_ff[g] <= nxt_linePlus[g];
        lineMinus_ff[g] <= nxt_lineMinus[g];
      end
    end
  end
endmodule : qltsi_tx_system_interface
`default_nettype wire

// ==== hw/qltsi_pkg.sv ====
// constants and carriers shared by the quad transmit system interface
`default_nettype none
package qltsi_pkg;
  localparam int NUM_CH = 4;
  // register indexes; byte address is four times the index
  localparam logic [6:0] IDX_CH_CTRL0 = 7'h00;
  localparam logic [6:0] IDX_GLOBAL = 7'h42;
  localparam logic [6:0] IDX_STATUS = 7'h43;
  localparam int APB_ADDR_W = 12;
  localparam int APB_IDX_LSB = 2;
  localparam int APB_IDX_MSB = 8;
  // channel control fields
  localparam int CC_TX_EN = 0;
  localparam int CC_CODEC_EN = 1;
  localparam int CC_ALL_ONES = 2;
  localparam int CC_RX_PWR = 3;
  localparam logic [7:0] CC_WMASK = 8'h0f;
  localparam logic [7:0] CC_RST = 8'h0a;
  // global control fields
  localparam int GC_SINGLE_RAIL = 0;
  localparam int GC_E1 = 1;
  localparam int GC_RISING = 2;
  localparam int GC_PIN_HANDOVER = 6;
  localparam logic [7:0] GC_WMASK = 8'h47;
  localparam logic [7:0] GC_RST = 8'h04;
  // status fields
  localparam int ST_HOST = 0;
  localparam int ST_SINGLE_RAIL = 1;
  localparam int ST_E1 = 2;
  localparam int ST_TX_EN_LSB = 4;
  // line symbols held in the substitution delay line
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_MARK = 2'h1;
  localparam logic [1:0] SYM_BIP = 2'h2;
  localparam logic [1:0] SYM_VIOL = 2'h3;
  localparam logic [2:0] TAP_AMI = 3'h0;
  localparam logic [2:0] TAP_HDB3 = 3'h3;
  localparam logic [2:0] TAP_B8ZS = 3'h7;
  // substitution patterns, newest bit in the low symbol
  localparam logic [15:0] PAT_B8ZS = 16'h038e;
  localparam logic [15:0] MASK_B8ZS = 16'hffff;
  localparam logic [15:0] PAT_HDB3_ODD = 16'h0003;
  localparam logic [15:0] PAT_HDB3_EVEN = 16'h0083;
  localparam logic [15:0] MASK_HDB3 = 16'h00ff;
  // nominal line clock rates and the system clock period
  localparam int T1_RATE_KHZ = 1544;
  localparam int E1_RATE_KHZ = 2048;
  localparam int CLK_PERIOD_NS = 5;

  typedef struct packed {
    logic clk;
    logic plus;
    logic minus;
    logic allOnes;
    logic txOn;
  } qltsi_chan_pins_t;

  typedef struct packed {
    logic ctlSrc;
    logic edgeSel;
    logic singleRail;
    logic e1;
    logic busStyle;
    logic [6:0] addr;
    logic [7:0] data;
  } qltsi_glob_pins_t;
endpackage : qltsi_pkg
`default_nettype wire

// ==== verif/qltsi_tx_asserts.sv ====
// bus and pin-mode assertions for the transmit system interface
`timescale 1ns/100ps
`default_nettype none
module qltsi_tx_asserts
  import qltsi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [NUM_CH-1:0] txSectionEnable,
  input wire logic controlSourceSelect,
  input wire logic busDataOe,
  input wire logic [NUM_CH-1:0] lineOutOe,
  input wire logic [NUM_CH-1:0] rxPowerOn,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // no wait states, so every access phase ends at once
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_err_only_access;
    pslverr |-> psel && penable;
  endproperty
  a_err_only_access: assert property (p_err_only_access) else $error("stray pslverr");
  property p_unmapped;
    psel && penable && paddr[11:9] != 3'h0 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_global_ok;
    psel && penable && paddr == 12'h108 |-> !pslverr;
  endproperty
  a_global_ok: assert property (p_global_ok) else $error("global refused");
  property p_upper_zero;
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  // sync flops delay pins two cycles, hence the four-cycle window
  property p_pin_txen;
    (controlSourceSelect && $stable(txSectionEnable)) [*4] |-> lineOutOe == txSectionEnable;
  endproperty
  a_pin_txen: assert property (p_pin_txen) else $error("enable pin not obeyed");
  property p_pin_rx_on;
    controlSourceSelect [*4] |-> rxPowerOn == 4'hf;
  endproperty
  a_pin_rx_on: assert property (p_pin_rx_on) else $error("receiver off in pin mode");
  property p_pin_bus_off;
    controlSourceSelect [*5] |-> !busDataOe;
  endproperty
  a_pin_bus_off: assert property (p_pin_bus_off) else $error("data bus driven in pin mode");
endmodule : qltsi_tx_asserts
bind qltsi_tx_system_interface qltsi_tx_asserts u_chk (.clk, .srst, .txSectionEnable,
  .controlSourceSelect, .busDataOe, .lineOutOe, .rxPowerOn, .paddr, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr);
`default_nettype wire

// ==== verif/qltsi_framer_model.sv ====
// framer model: line clock and rail data for all four channels
`timescale 1ns/100ps
`default_nettype none
module qltsi_framer_model
  import qltsi_pkg::*;
(
  output logic [NUM_CH-1:0] lineClk,
  output logic [NUM_CH-1:0] plusOut,
  output logic [NUM_CH-1:0] minusOut
);
  // idle: clock still, rails driven low
  initial begin
    lineClk = '0;
    plusOut = '0;
    minusOut = '0;
  end
  // data moves midway through the low phase, clear of both sample edges
  task automatic send(input logic [15:0] p, input logic [15:0] m, input int n,
      input realtime half);
    #1.3;
    for (int i = 0; i < n; i++) begin
      plusOut = {NUM_CH{p[i]}};
      minusOut = {NUM_CH{m[i]}};
      #(half / 2.0) lineClk = '1;
      #(half) lineClk = '0;
      #(half / 2.0);
    end
    plusOut = '0;
    minusOut = '0;
  endtask : send
endmodule : qltsi_framer_model
`default_nettype wire

// ==== verif/quad_line_tx_system_interface_tb.sv ====
// self-checking bench for the quad transmit system interface
`timescale 1ns/100ps
`default_nettype none
module quad_line_tx_system_interface_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] allOnes = 4'h0;
  logic [3:0] txSectionEnable = 4'hf;
  logic controlSourceSelect = 1'b1;
  logic singleRailSelect = 1'b0;
  logic edgeSel = 1'b1;
  logic [6:0] busAddr = 7'h00;
  logic [7:0] busDataIn = 8'h00;
  logic [7:0] bdo;
  logic boe;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err;
  logic [3:0] lineClk, fp, fm, lp, lm, loe, rxp;
  int miscompares = 0;
  int samples_checked = 0;

  always #2.5 clk = ~clk;

  qltsi_tx_system_interface dut (
    .clk, .srst, .txLineClock(lineClk), .txPlusRailIn(fp), .txMinusRailIn(fm),
    .txAllOnesCmd(allOnes), .txSectionEnable, .controlSourceSelect,
    .txClockEdgeSelect(edgeSel), .singleRailSelect, .e1StandardSelect(1'b0),
    .busStyleSelect(1'b0), .busAddr, .busDataIn, .busDataOut(bdo),
    .busDataOe(boe), .lineOutPlus(lp), .lineOutMinus(lm), .lineOutOe(loe),
    .rxPowerOn(rxp), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr
  );
  qltsi_framer_model fr (.lineClk, .plusOut(fp), .minusOut(fm));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int w;
    w = 0;
    @(posedge clk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (w >= 20) chk("pready", 32'h1, 32'h0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset();
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : do_reset

  task automatic test_regs();
    apb(1'b0, 12'h108, 32'h0, rd, err);
    chk("global reset", 32'h04, rd);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk("chan ctrl reset", 32'h0a, rd);
    apb(1'b1, 12'h108, 32'hffffffff, rd, err);
    apb(1'b0, 12'h108, 32'h0, rd, err);
    chk("global mask", 32'h47, rd);
    apb(1'b0, 12'h140, 32'h0, rd, err);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask : test_regs

  // bus strobes must idle high while the pins serve the host port
  task automatic test_host();
    allOnes <= 4'hf;
    controlSourceSelect <= 1'b0;
    txSectionEnable <= 4'b1001;
    apb(1'b1, 12'h108, 32'h04, rd, err);
    apb(1'b1, 12'h008, 32'h0b, rd, err);
    apb(1'b1, 12'h004, 32'h02, rd, err);
    repeat (4) @(posedge clk);
    chk("host tx enable", 32'h4, {28'h0, loe});
    chk("host rx power", 32'hd, {28'h0, rxp});
    apb(1'b1, 12'h108, 32'h44, rd, err);
    repeat (4) @(posedge clk);
    chk("handover tx enable", 32'h9, {28'h0, loe});
    controlSourceSelect <= 1'b1;
    repeat (5) @(posedge clk);
    chk("pin rx power", 32'hf, {28'h0, rxp});
    allOnes <= 4'h0;
  endtask : test_host

  // write-strobe port: pin write to the global register, then pin read back
  task automatic test_strobe();
    controlSourceSelect <= 1'b0;
    allOnes <= 4'hf;
    busAddr <= 7'h42;
    busDataIn <= 8'h05;
    repeat (4) @(posedge clk);
    allOnes <= 4'h7;
    repeat (4) @(posedge clk);
    allOnes <= 4'h6;
    repeat (4) @(posedge clk);
    allOnes <= 4'h7;
    repeat (5) @(posedge clk);
    apb(1'b0, 12'h108, 32'h0, rd, err);
    chk("strobe write", 32'h05, rd);
    allOnes <= 4'h5;
    repeat (5) @(posedge clk);
    chk("strobe read oe", 32'h1, {31'h0, boe});
    chk("strobe read data", 32'h05, {24'h0, bdo});
    allOnes <= 4'hf;
    controlSourceSelect <= 1'b1;
    repeat (5) @(posedge clk);
    allOnes <= 4'h0;
  endtask : test_strobe

  // mode 0 dual rail, 1 single-rail ami, 2 all ones
  task automatic run_frame(input logic [15:0] p, input logic [15:0] m, input int n,
      input int mode, input logic fall, input realtime half);
    logic pol;
    logic mk;
    logic [1:0] e;
    pol = 1'b1;
    fork
      fr.send(p, m, n, half);
      for (int i = 0; i < n; i++) begin
        if (fall) @(negedge lineClk[0]);
        else @(posedge lineClk[0]);
        repeat (7) @(posedge clk);
        mk = p[i] | (mode == 2);
        e = (mode == 0) ? {p[i], m[i]} : (mk ? {pol, !pol} : 2'b00);
        if (mode != 0 && mk) pol = !pol;
        chk("line plus", {28'h0, {4{e[1]}}}, {28'h0, lp});
        chk("line minus", {28'h0, {4{e[0]}}}, {28'h0, lm});
      end
    join
  endtask : run_frame

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    test_regs();
    test_host();
    test_strobe();
    do_reset();
    run_frame(16'ha5c3, 16'h5a3c, 16, 0, 1'b0, 40.0);
    run_frame(16'hff00, 16'h0ff0, 16, 0, 1'b0, 61.3);
    edgeSel <= 1'b0;
    repeat (3) @(posedge clk);
    run_frame(16'h3c96, 16'hc369, 16, 0, 1'b1, 40.0);
    edgeSel <= 1'b1;
    do_reset();
    singleRailSelect <= 1'b1;
    run_frame(16'hb3d5, 16'hffff, 16, 1, 1'b0, 40.0);
    do_reset();
    allOnes <= 4'hf;
    repeat (5) @(posedge clk);
    run_frame(16'h0000, 16'hffff, 8, 2, 1'b0, 40.0);
    txSectionEnable <= 4'b0101;
    repeat (5) @(posedge clk);
    chk("pin tx enable", 32'h5, {28'h0, loe});
    report_and_stop();
  end

  // watchdog well beyond the few microseconds of traffic
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
endmodule : quad_line_tx_system_interface_tb
`default_nettype wire
